//--- rtl/rsc_ctrl.sv
// Purpose: Reset source register, reset sequencing and reset pin drive.
// Assumes: All inputs synchronous to CLK; SYS_RST is the power-up reset.
// Notes:   APB slave answers with one wait-free access phase.
// What this block does
// - Bit 5 write enables comparator low reset.
// - Bit 2 enables clock detector, reads its flag.
// - Detector resets after clock absent for timeout.
// - Bit 1 selects supply monitor, not power.
// - Bit 1 reads 1 after any power-on reset.
// - Other flags undefined while power-on flag set.
// - Bit 0 write 1 forces power-on, pin low.
// - Bit 0 reads 1 after reset pin reset.
// - Power-on holds reset pin low for delay.
`timescale 1ns/1ps
module rsc_ctrl
	import rsc_pkg::*;
#(
	parameter int MCD_CYCLES = MCD_CYCLES_DEF,
	parameter int POR_CYCLES = POR_CYCLES_DEF
)
(
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic              COMP_OUT,
	input  wire logic              WDT_TIMEOUT,
	input  wire logic              SUPPLY_LOW,
	input  wire logic              SUPPLY_MONITOR_ENABLE_PIN,
	input  wire logic              CORE_CLK_TICK,
	input  wire logic              RST_PIN_IN,
	output logic                   RST_PIN_OUT,
	output logic                   RST_PIN_OE,
	output logic                   SYS_RESET_OUT,
	output logic                   IRQ
);
	localparam logic [TMR_W-1:0] POR_LOAD = TMR_W'(POR_CYCLES);
	localparam logic [TMR_W-1:0] MCD_LOAD = TMR_W'(MCD_CYCLES);
	localparam logic [TMR_W-1:0] INT_LOAD = TMR_W'(INT_RST_CYCLES);
	rsc_state_e           state_q, state_d;
	logic [CAUSE_W-1:0]   cause_q, cause_d, sts_q, mask_q;
	logic                 comp_en_q, mcd_en_q, mon_sel_q;
	logic                 cause_load, clr_en, st_run;
	logic                 pready_q, pslverr_q, pin_oe_q, pin_out_q;
	logic                 sys_reset_q, irq_q;
	logic [31:0]          prdata_q, rd_mux;
	logic                 setup, acc_done, addr_hit;
	logic                 wr_rce, wr_mask, rd_sts;
	logic                 force_por, sw_trig, por_trig, pin_trig;
	logic                 mcd_trig, wdt_trig, comp_trig;
	rsc_tmr_if hold_if ();
	rsc_tmr_if mcd_if ();

	// Hold timer times both the power-on delay and internal pulses.
	rsc_timer #(.INIT(POR_LOAD)) u_hold_tmr
	(
		.clk (CLK),
		.rst (SYS_RST),
		.tmr (hold_if)
	);

	// Missing clock detector: reloaded by every core clock tick.
	rsc_timer #(.INIT(MCD_LOAD)) u_mcd_tmr
	(
		.clk (CLK),
		.rst (SYS_RST),
		.tmr (mcd_if)
	);

	// APB decode; the answer comes in the first access cycle.
	assign setup    = PSEL && !PENABLE;
	assign acc_done = PSEL && PENABLE && pready_q;
	assign addr_hit = (PADDR == ADDR_RCE) || (PADDR == ADDR_STS)
		|| (PADDR == ADDR_MASK);
	assign wr_rce   = acc_done && PWRITE && (PADDR == ADDR_RCE);
	assign wr_mask  = acc_done && PWRITE && (PADDR == ADDR_MASK);
	assign rd_sts   = acc_done && !PWRITE && (PADDR == ADDR_STS);

	// Reads of the cause register show flags, not the enables.
	always_comb
	begin
		rd_mux = 32'h00000000;
		case (PADDR)
			ADDR_RCE:  rd_mux[CAUSE_W-1:0] = cause_q;
			ADDR_STS:  rd_mux[CAUSE_W-1:0] = sts_q;
			ADDR_MASK: rd_mux[CAUSE_W-1:0] = mask_q;
			default:   rd_mux = 32'h00000000;
		endcase
	end

	// Bus answer registers, loaded in the setup cycle.
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end
		else
		begin
			pready_q  <= setup;
			pslverr_q <= setup && !addr_hit;
			prdata_q  <= (setup && !PWRITE) ? rd_mux : 32'h00000000;
		end
	end

	// Reset source triggers; the enables gate each optional source.
	assign st_run    = (state_q == ST_RUN);
	assign force_por = wr_rce && PWDATA[B_PIN];
	assign sw_trig   = wr_rce && PWDATA[B_SW];
	assign por_trig  = force_por || (SUPPLY_MONITOR_ENABLE_PIN
		&& mon_sel_q && SUPPLY_LOW);
	assign pin_trig  = !RST_PIN_IN;
	assign mcd_trig  = mcd_en_q && mcd_if.expired;
	assign wdt_trig  = WDT_TIMEOUT;
	assign comp_trig = comp_en_q && !COMP_OUT;

	// The detector is only armed while enabled and the system runs.
	assign mcd_if.load     = CORE_CLK_TICK || !mcd_en_q || !st_run;
	assign mcd_if.load_val = MCD_LOAD;
	assign mcd_if.en       = 1'b1;

	// Sequencer: power-on type resets win over everything, even mid-hold.
	always_comb
	begin
		state_d          = state_q;
		cause_d          = cause_q;
		cause_load       = 1'b0;
		clr_en           = 1'b0;
		hold_if.load     = 1'b0;
		hold_if.load_val = INT_LOAD;
		if (por_trig)
		begin
			state_d          = ST_POR;
			cause_d          = CAUSE_POR;
			cause_load       = 1'b1;
			hold_if.load     = 1'b1;
			hold_if.load_val = POR_LOAD;
		end
		else
		begin
			case (state_q)
				ST_RUN:
				begin
					cause_load   = pin_trig || mcd_trig || wdt_trig
						|| comp_trig || sw_trig;
					hold_if.load = cause_load;
					if (pin_trig)
					begin
						state_d = ST_PIN;
						cause_d = CAUSE_PIN;
					end
					else if (mcd_trig)
					begin
						state_d = ST_INT;
						cause_d = CAUSE_MCD;
					end
					else if (wdt_trig)
					begin
						state_d = ST_INT;
						cause_d = CAUSE_WDT;
					end
					else if (comp_trig)
					begin
						state_d = ST_INT;
						cause_d = CAUSE_COMP;
					end
					else if (sw_trig)
					begin
						state_d = ST_INT;
						cause_d = CAUSE_SW;
					end
				end
				ST_POR, ST_INT:
					if (hold_if.expired)
						state_d = ST_RUN;
				ST_PIN:
					if (RST_PIN_IN)
						state_d = ST_RUN;
				default:
					state_d = ST_POR;
			endcase
		end
		clr_en = cause_load;
	end

	assign hold_if.en = (state_q == ST_POR) || (state_q == ST_INT);

	// State and cause flags; only one cause bit is ever set at a time.
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			state_q <= ST_POR;
			cause_q <= CAUSE_POR;
		end
		else
		begin
			state_q <= state_d;
			cause_q <= cause_d;
		end
	end

	// Enables clear on any reset the block starts; the monitor select
	// survives so the supply monitor stays a source unless deselected.
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			comp_en_q <= 1'b0;
			mcd_en_q  <= 1'b0;
			mon_sel_q <= 1'b1;
		end
		else if (clr_en)
		begin
			comp_en_q <= 1'b0;
			mcd_en_q  <= 1'b0;
		end
		else if (wr_rce)
		begin
			comp_en_q <= PWDATA[B_COMP];
			mcd_en_q  <= PWDATA[B_MCD];
			mon_sel_q <= PWDATA[B_POR];
		end
	end

	// Sticky status: only the bits returned by the read are cleared,
	// so an event landing during the read is kept.
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			sts_q <= STS_RST;
		else
			sts_q <= (sts_q & ~(rd_sts ? prdata_q[CAUSE_W-1:0]
				: CAUSE_NONE)) | (cause_load ? cause_d : CAUSE_NONE);
	end

	// Interrupt mask.
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			mask_q <= MASK_RST;
		else if (wr_mask)
			mask_q <= PWDATA[CAUSE_W-1:0];
	end

	// Registered outputs; the pin is driven only in the power-on hold.
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			pin_oe_q    <= 1'b1;
			pin_out_q   <= 1'b0;
			sys_reset_q <= 1'b1;
			irq_q       <= 1'b0;
		end
		else
		begin
			pin_oe_q    <= (state_d == ST_POR);
			pin_out_q   <= 1'b0;
			sys_reset_q <= (state_d != ST_RUN);
			irq_q       <= |(sts_q & mask_q);
		end
	end

	assign PRDATA        = prdata_q;
	assign PREADY        = pready_q;
	assign PSLVERR       = pslverr_q;
	assign RST_PIN_OUT   = pin_out_q;
	assign RST_PIN_OE    = pin_oe_q;
	assign SYS_RESET_OUT = sys_reset_q;
	assign IRQ           = irq_q;

	// Helper counters for the timing checks below.
	logic [TMR_W:0] por_len_q;
	logic [TMR_W:0] idle_q;
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			por_len_q <= '0;
			idle_q    <= '0;
		end
		else
		begin
			por_len_q <= pin_oe_q ? por_len_q + 1'b1 : '0;
			idle_q    <= (st_run && mcd_en_q && !CORE_CLK_TICK)
				? idle_q + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_hold_enter;
		$rose(pin_oe_q);
	endsequence
	sequence s_hold_leave;
		$fell(pin_oe_q);
	endsequence
	a_comp_source: assert property ((st_run && comp_trig && !por_trig
		&& !pin_trig && !mcd_trig && !wdt_trig)
		|=> sys_reset_q && cause_q == CAUSE_COMP)
		else $error("comparator reset not taken");
	a_comp_gated: assert property ((st_run && !comp_en_q && !COMP_OUT
		&& !por_trig && !pin_trig && !mcd_trig && !wdt_trig && !sw_trig)
		|=> !sys_reset_q)
		else $error("disabled comparator caused a reset");
	a_sw_internal: assert property ((st_run && sw_trig && !por_trig
		&& !pin_trig && !mcd_trig && !wdt_trig && !comp_trig)
		|=> cause_q == CAUSE_SW && sys_reset_q && !pin_oe_q)
		else $error("software reset wrong");
	a_wdt_flag: assert property ((st_run && wdt_trig && !por_trig
		&& !pin_trig && !mcd_trig) |=> cause_q == CAUSE_WDT)
		else $error("watchdog flag missing");
	a_mcd_timeout: assert property (idle_q <= MCD_CYCLES + 2)
		else $error("missing clock not detected in time");
	a_monitor_sel: assert property ((SUPPLY_LOW
		&& SUPPLY_MONITOR_ENABLE_PIN && mon_sel_q) |=> pin_oe_q)
		else $error("supply monitor reset not taken");
	a_por_flag: assert property (s_hold_enter |-> cause_q == CAUSE_POR)
		else $error("power-on flag not set");
	a_force_por: assert property (force_por
		|=> pin_oe_q && !pin_out_q && cause_q[B_POR])
		else $error("forced power-on reset not taken");
	a_pin_flag: assert property ((st_run && pin_trig && !por_trig)
		|=> cause_q == CAUSE_PIN && sys_reset_q && !pin_oe_q)
		else $error("pin reset not recorded");
	a_por_hold: assert property (s_hold_leave
		|-> por_len_q >= POR_CYCLES)
		else $error("reset pin released too early");
endmodule // rsc_ctrl

//--- rtl/rsc_pkg.sv
// Purpose: Shared constants and types of the reset source control block.
// Assumes: 40 MHz system clock, APB register access with 32-bit data.
// Notes:   Long counts are defaults for top-level parameters.
package rsc_pkg;

	// Clock rate and the documented times in their own units.
	localparam int CLK_MHZ        = 40;
	localparam int MCD_TIMEOUT_US = 220;
	localparam int POR_DELAY_MS   = 100;
	localparam int US_PER_MS      = 1000;
	localparam int MCD_CYCLES_DEF = MCD_TIMEOUT_US * CLK_MHZ;
	localparam int POR_CYCLES_DEF = POR_DELAY_MS * US_PER_MS * CLK_MHZ;

	// Hold count of an internal (pin not driven) system reset; the pulse lasts one cycle more.
	localparam int INT_RST_CYCLES = 4;

	// Down-counter width; holds the power-on delay count.
	localparam int TMR_W = 22;
	localparam logic [TMR_W-1:0] TMR_ZERO = 22'h000000;
	localparam logic [TMR_W-1:0] TMR_ONE  = 22'h000001;

	// Register byte addresses on the APB.
	localparam int          ADDR_W    = 8;
	localparam logic [7:0]  ADDR_RCE  = 8'h00;
	localparam logic [7:0]  ADDR_STS  = 8'h04;
	localparam logic [7:0]  ADDR_MASK = 8'h08;

	// Bit positions of the reset_cause_and_enable register.
	localparam int B_PIN  = 0;
	localparam int B_POR  = 1;
	localparam int B_MCD  = 2;
	localparam int B_WDT  = 3;
	localparam int B_SW   = 4;
	localparam int B_COMP = 5;
	localparam int CAUSE_W = 6;

	// One-hot cause codes; status and mask share this layout.
	localparam logic [CAUSE_W-1:0] CAUSE_PIN  = 6'h01;
	localparam logic [CAUSE_W-1:0] CAUSE_POR  = 6'h02;
	localparam logic [CAUSE_W-1:0] CAUSE_MCD  = 6'h04;
	localparam logic [CAUSE_W-1:0] CAUSE_WDT  = 6'h08;
	localparam logic [CAUSE_W-1:0] CAUSE_SW   = 6'h10;
	localparam logic [CAUSE_W-1:0] CAUSE_COMP = 6'h20;
	localparam logic [CAUSE_W-1:0] CAUSE_NONE = 6'h00;

	// Reset values.
	localparam logic [CAUSE_W-1:0] STS_RST  = 6'h02;
	localparam logic [CAUSE_W-1:0] MASK_RST = 6'h00;

	// Reset sequencer states.
	typedef enum logic [1:0] {ST_POR, ST_INT, ST_PIN, ST_RUN} rsc_state_e;

endpackage

//--- rtl/rsc_timer.sv
// Purpose: Loadable down-counter that flags when it has reached zero.
// Assumes: Load wins over counting.
// Notes:   Stops at zero; the reset value comes from a parameter.
`timescale 1ns/1ps
module rsc_timer
	import rsc_pkg::*;
#(
	parameter logic [TMR_W-1:0] INIT = TMR_ZERO
)
(
	input wire logic clk,
	input wire logic rst,
	rsc_tmr_if.cnt   tmr
);
	logic [TMR_W-1:0] cnt_q;

	// Count down while enabled; a load restarts the interval.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= INIT;
		else if (tmr.load)
			cnt_q <= tmr.load_val;
		else if (tmr.en && cnt_q != TMR_ZERO)
			cnt_q <= cnt_q - TMR_ONE;
	end

	assign tmr.expired = (cnt_q == TMR_ZERO);
endmodule // rsc_timer

//--- rtl/rsc_tmr_if.sv
// Purpose: Carries load, enable and expiry between sequencer and timer.
// Assumes: One clock domain.
// Notes:   The count width is fixed by the package.
`timescale 1ns/1ps
interface rsc_tmr_if
	import rsc_pkg::*;
();
	logic             load;
	logic [TMR_W-1:0] load_val;
	logic             en;
	logic             expired;

	modport ctrl (output load, output load_val, output en, input expired);
	modport cnt  (input load, input load_val, input en, output expired);
endinterface

//--- tb/rsc_far_side.sv
// Purpose: Far side of the reset block: pin wire, reset sources, clock ticks.
// Assumes: The bench steers every source through the control inputs.
// Notes:   The reset pin has a pull-up, so a released pin reads high.
`timescale 1ns/1ps
module rsc_far_side
(
	input  wire logic pin_press,
	input  wire logic comp_low,
	input  wire logic wdt_fire,
	input  wire logic sup_low,
	input  wire logic mon_on,
	input  wire logic clk_stop,
	input  wire logic pin_oe,
	output logic      comp_out,
	output logic      wdt_timeout,
	output logic      supply_low,
	output logic      mon_en_pin,
	output logic      clk_tick,
	output logic      pin_in
);
	// Open-drain wire: any party that pulls low wins over the pull-up.
	assign pin_in = !(pin_press || pin_oe);
	// The comparator idles high, so only a deliberate low asks for reset.
	assign comp_out = !comp_low;
	assign wdt_timeout = wdt_fire;
	assign supply_low = sup_low;
	assign mon_en_pin = mon_on; // Strap only, never touched by writes.
	// A tick every cycle while the monitored clock runs.
	assign clk_tick = !clk_stop;
endmodule // rsc_far_side

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the reset source control block.
// Assumes: Short hold counts are set through the top parameters.
// Notes:   Transfers leave one idle cycle between them, to keep it simple.
`timescale 1ns/1ps
module tb_top
	import rsc_pkg::*;
;
	localparam int MCD = 20;
	localparam int POR = 30;
	localparam int IR  = INT_RST_CYCLES + 1;
	logic              clk = 1'b0, rst = 1'b1;
	logic              psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0]       pwd = 32'h0, prd, rdat, rv;
	logic              prdy, perr, rerr, oe, pout, sres, irq;
	logic              comp = 1'b0, wdt = 1'b0, sup = 1'b0, mon = 1'b1;
	logic              stop = 1'b0, press = 1'b0;
	logic              cout, wout, slow, monp, tick, pin;
	int                err_count = 0, total_checks = 0, wn = 0, n;
	int                seed = 32'h02C3;

	// Design under test with shortened hold counts.
	rsc_ctrl #(.MCD_CYCLES(MCD), .POR_CYCLES(POR)) i_rsc_ctrl (
		.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd),
		.PREADY(prdy), .PSLVERR(perr), .COMP_OUT(cout),
		.WDT_TIMEOUT(wout), .SUPPLY_LOW(slow),
		.SUPPLY_MONITOR_ENABLE_PIN(monp), .CORE_CLK_TICK(tick),
		.RST_PIN_IN(pin), .RST_PIN_OUT(pout), .RST_PIN_OE(oe),
		.SYS_RESET_OUT(sres), .IRQ(irq));
	// Pin wire and the reset sources.
	rsc_far_side i_rsc_far_side (
		.pin_press(press), .comp_low(comp), .wdt_fire(wdt),
		.sup_low(sup), .mon_on(mon), .clk_stop(stop), .pin_oe(oe),
		.comp_out(cout), .wdt_timeout(wout), .supply_low(slow),
		.mon_en_pin(monp), .clk_tick(tick), .pin_in(pin));

	// Free-running 40 MHz clock.
	always #12.5 clk = ~clk;

	// Prints the counts and the verdict, then stops the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] seen, want);
		total_checks++;
		if (seen !== want)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, want, seen);
		end
	endtask

	// Only the six cause bits of the mask exist; the rest read zero.
	function automatic logic [31:0] mask_exp(input logic [31:0] w);
		return w & {26'h0, 6'h3F};
	endfunction

	// A wait that runs out is a mismatch and ends the run.
	task automatic tmo();
		err_count++;
		$display("FAIL timeout expected event seen none");
		test_done();
	endtask

	// One APB transfer; waits for PREADY rather than assuming a latency.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Answer is taken at the rising edge that sees ready high.
		for (k = 0; k < 20; k++)
		begin
			@(posedge clk);
			if (prdy === 1'b1)
			begin
				rdat = prd;
				rerr = perr;
				break;
			end
		end
		if (k == 20)
			tmo();
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// Waits for the system reset to reach a level; wn counts the cycles.
	task automatic wait_lvl(input logic v, input int lim);
		wn = 0;
		while (sres !== v)
		begin
			if (wn == lim)
				tmo();
			wn++;
			@(negedge clk);
		end
	endtask

	// Checks that no reset starts for m cycles.
	task automatic quiet(input int m);
		repeat (m)
		begin
			@(negedge clk);
			chk("no_reset", 32'(sres), 32'h0);
		end
	endtask

	// Follows one whole reset, its pin drive and its length.
	task automatic hold(input logic o, input int lo, hi);
		wait_lvl(1'b1, MCD + 10);
		chk("pin_drive", 32'(oe), 32'(o));
		chk("pin_level", 32'(pout), 32'h0);
		wait_lvl(1'b0, POR + 10);
		chk("hold_len", 32'(wn >= lo && wn <= hi), 32'h1);
		chk("pin_free", 32'(oe), 32'h0);
	endtask

	// Reads the cause register and compares the bits in m.
	task automatic cause(input logic [5:0] c, input logic [31:0] m);
		apb(1'b0, ADDR_RCE, 32'h0);
		chk("cause", rdat & m, {26'h0, c} & m);
	endtask

	// Main sequence.
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wait_lvl(1'b0, POR + 10);
		chk("por_len", 32'(wn >= POR && wn <= POR + 2), 32'h1);
		// Only the power-on flag is compared; the other flags are undefined after this kind of reset.
		cause(CAUSE_POR, 32'h2);
		apb(1'b0, ADDR_STS, 32'h0);
		chk("status", rdat, {26'h0, STS_RST});
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped_err", 32'(rerr), 32'h1);
		chk("unmapped_data", rdat, 32'h0);
		repeat (4)
		begin
			rv = $random(seed);
			apb(1'b1, ADDR_MASK, rv);
			apb(1'b0, ADDR_MASK, 32'h0);
			chk("mask", rdat, mask_exp(rv));
		end
		apb(1'b1, ADDR_MASK, {26'h0, CAUSE_WDT});
		$display("test setup done");
		apb(1'b1, ADDR_RCE, 32'h12);
		hold(1'b0, IR, IR);
		cause(CAUSE_SW, '1);
		chk("irq_masked", 32'(irq), 32'h0);
		wdt <= 1'b1;
		@(posedge clk) wdt <= 1'b0;
		hold(1'b0, IR, IR);
		cause(CAUSE_WDT, '1);
		chk("irq", 32'(irq), 32'h1);
		apb(1'b0, ADDR_STS, 32'h0);
		chk("status", rdat, 32'h18);
		repeat (2) @(negedge clk);
		chk("irq_clear", 32'(irq), 32'h0);
		$display("test sw and watchdog done");
		apb(1'b1, ADDR_RCE, 32'h02);
		comp <= 1'b1;
		quiet(10);
		@(posedge clk) comp <= 1'b0;
		apb(1'b1, ADDR_RCE, 32'h22);
		comp <= 1'b1;
		hold(1'b0, IR, IR);
		@(posedge clk) comp <= 1'b0;
		cause(CAUSE_COMP, '1);
		$display("test comparator done");
		apb(1'b1, ADDR_RCE, 32'h02);
		stop <= 1'b1;
		quiet(MCD + 10);
		@(posedge clk) stop <= 1'b0;
		apb(1'b1, ADDR_RCE, 32'h06);
		stop <= 1'b1;
		wait_lvl(1'b1, MCD + 10);
		chk("mcd_wait", 32'(wn >= MCD - 2), 32'h1);
		@(posedge clk) stop <= 1'b0;
		hold(1'b0, 1, IR);
		cause(CAUSE_MCD, '1);
		$display("test missing clock done");
		n = 2 + ($random(seed) & 3);
		press <= 1'b1;
		wait_lvl(1'b1, 5);
		chk("pin_drive", 32'(oe), 32'h0);
		repeat (n) @(posedge clk);
		press <= 1'b0;
		wait_lvl(1'b0, 10);
		cause(CAUSE_PIN, '1);
		$display("test pin done");
		apb(1'b1, ADDR_RCE, 32'h03);
		hold(1'b1, POR, POR + 2);
		cause(CAUSE_POR, 32'h2);
		$display("test forced power-on done");
		apb(1'b1, ADDR_RCE, 32'h00);
		sup <= 1'b1;
		quiet(8);
		@(posedge clk) sup <= 1'b0;
		mon <= 1'b0;
		apb(1'b1, ADDR_RCE, 32'h02);
		sup <= 1'b1;
		quiet(8);
		@(posedge clk) sup <= 1'b0;
		mon <= 1'b1;
		@(posedge clk) sup <= 1'b1;
		wait_lvl(1'b1, 5);
		chk("pin_drive", 32'(oe), 32'h1);
		@(posedge clk) sup <= 1'b0;
		wait_lvl(1'b0, POR + 10);
		chk("mon_len", 32'(wn >= POR - 2 && wn <= POR + 2), 32'h1);
		cause(CAUSE_POR, 32'h2);
		$display("test supply monitor done");
		test_done();
	end
endmodule // tb_top
